// ### include/arm_ctl_regs.vh
// Register offsets, field positions, encodings and reset values of the arming control block
`ifndef ARM_CTL_REGS_VH
`define ARM_CTL_REGS_VH
// APB word offsets (byte addresses)
`define OFS_CMD        12'h000
`define OFS_CFG_START  12'h004
`define OFS_CFG_STOP   12'h008
`define OFS_LEVEL_REQ  12'h00C
`define OFS_STATE      12'h010
`define OFS_IRQ_STAT   12'h014
`define OFS_IRQ_MASK   12'h018
`define OFS_MODE       12'h01C
// Command register fields (write only, self clearing)
`define CMD_CODE_LSB   0
`define CMD_CODE_MSB   3
`define CMD_INP_LSB    4
`define CMD_INP_MSB    5
// Command codes
`define CMD_ABORT      4'h1
`define CMD_INIT       4'h2
`define CMD_FUNC       4'h3
`define CMD_IMM_START  4'h4
`define CMD_IMM_STOP   4'h5
`define CMD_TRIGGER    4'h6
`define CMD_DONE       4'h7
// Qualifier config fields
`define CFG_SRC_LSB    0
`define CFG_SRC_MSB    2
`define CFG_SLOPE_BIT  3
`define CFG_LVL_LSB    4
`define CFG_LVL_MSB    5
// Source encodings
`define SRC_FRONT      3'h0
`define SRC_REAR       3'h1
`define SRC_IMM        3'h2
`define SRC_BUS        3'h3
`define SRC_HOLD       3'h4
// Level codes
`define LVL_ECL        2'h0
`define LVL_GND        2'h1
`define LVL_TTL        2'h2
// Level request thresholds in millivolts, signed 16 bit
`define LVL_LO_MV      16'hFC18
`define LVL_HI_MV      16'h03E8
// Reset values: source immediate, slope positive, level TTL
`define CFG_RESET      6'h22
// Level request after reset, 1600 mV
`define LVL_REQ_RESET  16'h0640
// Interrupt bits
`define IRQ_ARM_IGN    0
`define IRQ_CONFLICT   1
`define IRQ_DONE       2
// Error codes reported in the state register
`define ERR_ARM_IGN    8'hD4
`define ERR_CONFLICT   8'hCD
`endif

// ### rtl/level_quantizer.v
// Quantizes a requested trigger level in millivolts to one of three codes
`timescale 1ns/1ps
`include "arm_ctl_regs.vh"
module level_quantizer (
  input  wire [15:0] req_mv,   // Signed request in millivolts
  output reg  [1:0]  lvl_code  // Quantized level code
);
  // R14: three nominal bands
  always @* begin
    if ($signed(req_mv) < $signed(`LVL_LO_MV))
      lvl_code = `LVL_ECL;
    else if ($signed(req_mv) <= $signed(`LVL_HI_MV))
      lvl_code = `LVL_GND;
    else
      lvl_code = `LVL_TTL;
  end
endmodule

// ### rtl/arm_qualifier.v
// One arm qualifier: source select, slope edge detection and one-shot override
`timescale 1ns/1ps
`include "arm_ctl_regs.vh"
module arm_qualifier (
  input  wire       pclk,       // Clock
  input  wire       presetn,    // Async reset, active low
  input  wire [2:0] src,        // Programmed source
  input  wire       slope_neg,  // Falling edge when set
  input  wire [1:0] lvl,        // Programmed level code
  input  wire [2:0] front_cmp,  // Front comparator outputs per level code
  input  wire       rear_in,    // Rear trigger input, fixed TTL threshold
  input  wire       enable,     // Arming enabled by initiate
  input  wire       clear,      // Drop satisfaction once the wait for arm ends
  input  wire       imm_cmd,    // One-shot immediate arm
  input  wire       bus_trig,   // Bus trigger command
  output reg        sat_r       // Qualifier satisfied
);
  reg  sig_d_r;
  reg  sig;
  wire edge_hit;

  // R13: level picks the front comparator only; R16: rear uses TTL
  always @* begin
    case (src)
      `SRC_FRONT: sig = front_cmp[lvl];
      `SRC_REAR:  sig = rear_in;
      default:    sig = 1'b0;
    endcase
  end

  assign edge_hit = slope_neg ? (sig_d_r & ~sig) : (~sig_d_r & sig);

  // Previous sample for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sig_d_r <= 1'b0;
    else
      sig_d_r <= sig;
  end

  // R6: satisfaction per source; R15: imm always, hold waits, bus on trigger
  // R10: nothing arms unless enabled; R7 R8: override ignores source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sat_r <= 1'b0;
    else if (clear || !enable)
      sat_r <= 1'b0;
    else if (imm_cmd || src == `SRC_IMM)
      sat_r <= 1'b1;
    else if (src == `SRC_BUS && bus_trig)
      sat_r <= 1'b1;
    else if ((src == `SRC_FRONT || src == `SRC_REAR) && edge_hit)
      sat_r <= 1'b1;
  end
endmodule

// ### rtl/arm_ctl.v
// Measurement arming and sequencing controller with APB register access
//
// Contract
// R1: Abort ends measurement on addressed input and idles its sequencer.
// R2: Abort addresses one of three inputs; no number means input one.
// R3: In continuous mode abort drops current measurement then resumes.
// R4: New function or initiate aborts measurement in progress implicitly.
// R5: Host must send word-serial clear to leave a pending query.
// R6: Two independent start and stop qualifiers with source, slope, level; both level fields load from one level request.
// R7: Immediate start arm satisfies start now, current measurement only.
// R8: Immediate stop arm satisfies stop now, current measurement only.
// R9: After one-shot arm, settings stay; next measurement waits normally.
// R10: Configuration never arms; only initiate enables arming.
// R11: Immediate arm without initiated measurement is ignored, error -212.
// R12: Initiate moves addressed sequencer from idle to wait-for-arm.
// R13: Trigger level applies only to front-panel arm source.
// R14: Level request quantized to -1.3 V, 0 V or 1.6 V.
// R15: Immediate source always true; hold waits for immediate; bus waits trigger.
// R16: Rear-panel trigger source ignores level, uses TTL threshold.
// R17: Front start source with different stop source gives error -205 at initiate.
// R18: Outside continuous mode, completed measurement returns sequencer to idle.
`timescale 1ns/1ps
`include "arm_ctl_regs.vh"
module arm_ctl #(
  parameter NUM_INPUTS = 3               // Input channels
) (
  input  wire        pclk,               // APB clock, 200 MHz
  input  wire        presetn,            // Async reset, active low
  input  wire        psel,               // APB select
  input  wire        penable,            // APB enable
  input  wire        pwrite,             // APB write
  input  wire [11:0] paddr,              // APB byte address
  input  wire [31:0] pwdata,             // APB write data
  output wire [31:0] prdata,             // APB read data
  output wire        pready,             // APB ready, always high
  output wire        pslverr,            // APB error on unmapped address
  input  wire [2:0]  front_cmp,          // Front arm comparators per level code
  input  wire        rear_trig,          // Rear trigger input
  input  wire        meas_done,          // Measurement engine finished
  output reg  [2:0]  meas_run_r,         // Measuring, one bit per input
  output reg  [1:0]  front_lvl_r,        // Level code driven to front comparator
  output wire        irq                 // Level interrupt
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_MEAS = 2'h2;

  reg  [5:0]  cfg_start_r;
  reg  [5:0]  cfg_stop_r;
  reg  [15:0] lvl_req_r;
  reg  [2:0]  irq_stat_r;
  reg  [2:0]  irq_mask_r;
  reg  [2:0]  cont_r;
  reg  [7:0]  err_r;
  reg  [1:0]  st_r [0:2];
  reg  [1:0]  st_nxt [0:2];
  reg  [31:0] rdata_r;
  reg  [31:0] rd_mux;
  reg         map_hit;
  reg  [1:0]  act_r;
  wire        wr;
  wire        rd;
  wire        cmd_wr;
  wire [3:0]  cmd_code;
  wire [1:0]  cmd_inp;
  wire [1:0]  inp_idx;
  wire [1:0]  q_lvl;
  wire        start_sat;
  wire        stop_sat;
  wire        active;
  wire        conflict;
  wire        imm_any;
  wire        imm_ign;
  wire        arm_en;
  wire        arm_clr;
  integer     i;

  // Access on the enable phase; zero wait states
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~map_hit;
  assign prdata  = rdata_r;

  // Address decode
  always @* begin
    case (paddr)
      `OFS_CMD, `OFS_CFG_START, `OFS_CFG_STOP, `OFS_LEVEL_REQ,
      `OFS_STATE, `OFS_IRQ_STAT, `OFS_IRQ_MASK, `OFS_MODE: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  end

  assign cmd_wr   = wr & (paddr == `OFS_CMD);
  assign cmd_code = pwdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
  assign cmd_inp  = pwdata[`CMD_INP_MSB:`CMD_INP_LSB];
  // R2: input field 0 means default input one, 1..3 name inputs
  assign inp_idx  = (cmd_inp == 2'h0) ? 2'h0 : (cmd_inp - 2'h1);

  // R14: quantizer feeds the stored level code
  level_quantizer u_quant (
    .req_mv   (lvl_req_r),
    .lvl_code (q_lvl)
  );

  // Qualifier settings; writing them never arms (R10)
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_start_r <= `CFG_RESET;
      cfg_stop_r  <= `CFG_RESET;
      lvl_req_r   <= `LVL_REQ_RESET;
      irq_mask_r  <= 3'h0;
      cont_r      <= 3'h0;
    end else if (wr) begin
      case (paddr)
        `OFS_CFG_START: cfg_start_r <= {cfg_start_r[5:4], pwdata[3:0]};
        `OFS_CFG_STOP:  cfg_stop_r  <= {cfg_stop_r[5:4], pwdata[3:0]};
        `OFS_LEVEL_REQ: lvl_req_r   <= pwdata[15:0];
        `OFS_IRQ_MASK:  irq_mask_r  <= pwdata[2:0];
        `OFS_MODE:      cont_r      <= pwdata[2:0];
        default:        cont_r      <= cont_r;
      endcase
    end else begin
      // Quantized level lands in both qualifiers' level field
      cfg_start_r[5:4] <= q_lvl;
      cfg_stop_r[5:4]  <= q_lvl;
    end
  end

  // Shared arming hardware serves the channel that was last initiated
  assign active   = (st_r[act_r] != ST_IDLE);
  assign arm_en   = (st_r[act_r] == ST_WAIT);
  assign arm_clr  = (st_r[act_r] != ST_WAIT);
  assign imm_any  = cmd_wr & ((cmd_code == `CMD_IMM_START) | (cmd_code == `CMD_IMM_STOP));
  // R11: immediate arm outside wait state is ignored
  assign imm_ign  = imm_any & ~arm_en;
  // R17: front start with any other stop source
  assign conflict = (cfg_start_r[2:0] == `SRC_FRONT) && (cfg_stop_r[2:0] != `SRC_FRONT);

  arm_qualifier u_start (
    .pclk      (pclk),
    .presetn   (presetn),
    .src       (cfg_start_r[2:0]),
    .slope_neg (cfg_start_r[3]),
    .lvl       (cfg_start_r[5:4]),
    .front_cmp (front_cmp),
    .rear_in   (rear_trig),
    .enable    (arm_en),
    .clear     (arm_clr),
    .imm_cmd   (cmd_wr & (cmd_code == `CMD_IMM_START) & arm_en),
    .bus_trig  (cmd_wr & (cmd_code == `CMD_TRIGGER)),
    .sat_r     (start_sat)
  );

  arm_qualifier u_stop (
    .pclk      (pclk),
    .presetn   (presetn),
    .src       (cfg_stop_r[2:0]),
    .slope_neg (cfg_stop_r[3]),
    .lvl       (cfg_stop_r[5:4]),
    .front_cmp (front_cmp),
    .rear_in   (rear_trig),
    .enable    (arm_en),
    .clear     (arm_clr),
    .imm_cmd   (cmd_wr & (cmd_code == `CMD_IMM_STOP) & arm_en),
    .bus_trig  (cmd_wr & (cmd_code == `CMD_TRIGGER)),
    .sat_r     (stop_sat)
  );

  // Sequencer next state per input
  always @* begin
    for (i = 0; i < NUM_INPUTS; i = i + 1) begin
      st_nxt[i] = st_r[i];
      case (st_r[i])
        ST_IDLE: begin
          // R12: initiate enters wait-for-arm
          if (cmd_wr && cmd_code == `CMD_INIT && inp_idx == i && !conflict)
            st_nxt[i] = ST_WAIT;
        end
        ST_WAIT: begin
          if (i == act_r && start_sat && stop_sat)
            st_nxt[i] = ST_MEAS;
        end
        ST_MEAS: begin
          // R18: completion idles unless continuous
          if (meas_done && i == act_r)
            st_nxt[i] = cont_r[i] ? ST_WAIT : ST_IDLE;
        end
        default: st_nxt[i] = ST_IDLE;
      endcase
      // R1: abort idles the addressed input; R3: continuous resumes
      // R4: function select or initiate acts as an implied abort
      if (cmd_wr && inp_idx == i && st_r[i] != ST_IDLE &&
          (cmd_code == `CMD_ABORT || cmd_code == `CMD_FUNC || cmd_code == `CMD_INIT))
        st_nxt[i] = (cont_r[i] || cmd_code == `CMD_INIT) ? ST_WAIT : ST_IDLE;
    end
  end

  // Sequencer state and run outputs; R9: arm clears once wait ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 3; i = i + 1)
        st_r[i] <= ST_IDLE;
      meas_run_r  <= 3'h0;
      act_r       <= 2'h0;
      front_lvl_r <= `LVL_TTL;
    end else begin
      for (i = 0; i < NUM_INPUTS; i = i + 1) begin
        st_r[i]       <= st_nxt[i];
        meas_run_r[i] <= (st_nxt[i] == ST_MEAS);
      end
      if (cmd_wr && cmd_code == `CMD_INIT)
        act_r <= inp_idx;
      front_lvl_r <= cfg_start_r[5:4];
    end
  end

  // Error code and sticky events; set wins over read clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r      <= 8'h00;
      irq_stat_r <= 3'h0;
    end else begin
      // Clear only what the setup phase captured; later events stay pending
      if (rd && paddr == `OFS_IRQ_STAT)
        irq_stat_r <= irq_stat_r & ~rdata_r[2:0];
      // R11: arm ignored error
      if (imm_ign) begin
        err_r <= `ERR_ARM_IGN;
        irq_stat_r[`IRQ_ARM_IGN] <= 1'b1;
      end
      // R17: conflict reported at initiate
      if (cmd_wr && cmd_code == `CMD_INIT && conflict) begin
        err_r <= `ERR_CONFLICT;
        irq_stat_r[`IRQ_CONFLICT] <= 1'b1;
      end
      if (meas_done && st_r[act_r] == ST_MEAS)
        irq_stat_r[`IRQ_DONE] <= 1'b1;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux
  always @* begin
    case (paddr)
      `OFS_CFG_START: rd_mux = {26'h0, cfg_start_r};
      `OFS_CFG_STOP:  rd_mux = {26'h0, cfg_stop_r};
      `OFS_LEVEL_REQ: rd_mux = {16'h0, lvl_req_r};
      `OFS_STATE:     rd_mux = {13'h0, active, act_r, err_r, 2'h0, st_r[2], st_r[1], st_r[0]};
      `OFS_IRQ_STAT:  rd_mux = {29'h0, irq_stat_r};
      `OFS_IRQ_MASK:  rd_mux = {29'h0, irq_mask_r};
      `OFS_MODE:      rd_mux = {29'h0, cont_r};
      default:        rd_mux = 32'h0;
    endcase
  end

  // Read data registered in the setup phase so it is stable at access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rdata_r <= 32'h0;
    else if (psel && !penable && !pwrite)
      rdata_r <= rd_mux;
  end
endmodule

// ### bench/meas_engine_model.sv
// Measurement engine model: ends each run after a set latency
`timescale 1ns/1ps
module meas_engine_model (
  input  wire       pclk,      // Clock
  input  wire       presetn,   // Reset, low
  input  wire [2:0] meas_run,  // Run flags
  input  wire [7:0] lat,       // Run length
  output reg        meas_done  // Done pulse
);
  reg [8:0] cnt_r;  // Cycles in run
  // One pulse per run; a drop of the run restarts the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 9'h000;
      meas_done <= 1'b0;
    end else begin
      meas_done <= |meas_run && cnt_r == {1'b0, lat};
      cnt_r     <= !(|meas_run) ? 9'h000 : cnt_r + {8'h00, cnt_r <= {1'b0, lat}};
    end
  end
endmodule

// ### bench/arm_ctl_assertions.sv
// Port checks for the arming controller
`timescale 1ns/1ps
`include "arm_ctl_regs.vh"
module arm_ctl_checker (
  input wire        pclk,        // Clock
  input wire        presetn,     // Reset, low
  input wire        psel,        // Select
  input wire        penable,     // Enable
  input wire        pwrite,      // Write
  input wire [11:0] paddr,       // Address
  input wire [31:0] pwdata,      // Write data
  input wire [31:0] prdata,      // Read data
  input wire        pready,      // Ready
  input wire        pslverr,     // Error
  input wire [2:0]  front_cmp,   // Comparators
  input wire        rear_trig,   // Rear trigger
  input wire        meas_done,   // Engine done
  input wire [2:0]  meas_run_r,  // Run flags
  input wire [1:0]  front_lvl_r, // Level code
  input wire        irq          // Interrupt
);
  wire               acc = psel && penable;
  wire               wr  = acc && pwrite;
  wire               cwr = wr && paddr == `OFS_CMD;
  wire signed [15:0] mv  = pwdata[15:0];
  reg                mode0_r;  // Input one continuous
  reg         [1:0]  lvl_r;    // Expected level code
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadows of mode and level writes; the level check needs the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode0_r <= 1'b0;
      lvl_r   <= `LVL_TTL;
    end else begin
      if (wr && paddr == `OFS_MODE)
        mode0_r <= pwdata[0];
      if (wr && paddr == `OFS_LEVEL_REQ)
        lvl_r <= mv < -16'sh03E8 ? `LVL_ECL : (mv > 16'sh03E8 ? `LVL_TTL : `LVL_GND);
    end
  end
  // Refusal, reset state, masking, abort, function select, done and level checks
  property p_slverr; acc && paddr > 12'h01C |-> pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_rst; $rose(presetn) |-> meas_run_r == 3'h0 && front_lvl_r == `LVL_TTL && !irq; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_mask; wr && paddr == `OFS_IRQ_MASK && pwdata[2:0] == 3'h0 |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq high with all masked");
  property p_abort; cwr && pwdata[5:0] == {2'h2, `CMD_ABORT} |-> ##[1:3] !meas_run_r[1]; endproperty
  a_abort: assert property (p_abort) else $error("abort left input two running");
  property p_dflt; cwr && pwdata[5:0] == {2'h0, `CMD_ABORT} |-> ##[1:3] !meas_run_r[0]; endproperty
  a_dflt: assert property (p_dflt) else $error("plain abort missed input one");
  property p_func; cwr && pwdata[5:0] == {2'h1, `CMD_FUNC} |-> ##[1:3] !meas_run_r[0]; endproperty
  a_func: assert property (p_func) else $error("function select left run going");
  property p_done; meas_done && meas_run_r[0] && !mode0_r |-> ##[1:3] !meas_run_r[0] ##1 !meas_run_r[0] [*3];
  endproperty
  a_done: assert property (p_done) else $error("run did not end after done");
  property p_lvl; wr && paddr == `OFS_LEVEL_REQ |-> ##[1:3] front_lvl_r == lvl_r; endproperty
  a_lvl: assert property (p_lvl) else $error("level code wrong");
endmodule
bind arm_ctl arm_ctl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .front_cmp, .rear_trig, .meas_done, .meas_run_r, .front_lvl_r, .irq);

// ### bench/measurement_arming_control_tb_top.sv
// Self-checking bench of the arming controller with engine model
`timescale 1ns/1ps
`include "arm_ctl_regs.vh"
module measurement_arming_control_tb_top;
  reg         pclk, presetn, psel, penable, pwrite, rear_trig;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [2:0]  front_cmp;
  reg  [7:0]  lat;
  reg  signed [15:0] mv;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, meas_done;
  wire [2:0]  meas_run_r;
  wire [1:0]  front_lvl_r;
  integer     err_count, cmp_count, i, n;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  arm_ctl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .front_cmp, .rear_trig, .meas_done, .meas_run_r, .front_lvl_r, .irq);
  meas_engine_model i_eng (.pclk, .presetn, .meas_run(meas_run_r), .lat, .meas_done);
  // Expected level code of a request in millivolts
  function [1:0] qlvl(input signed [15:0] v);
    qlvl = v < -16'sh03E8 ? `LVL_ECL : (v > 16'sh03E8 ? `LVL_TTL : `LVL_GND);
  endfunction
  task report_and_stop;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One transfer; an idle edge after it keeps strobes from toggling twice at once
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        n = n + 1;
        if (n > 50) begin
          err_count = err_count + 1;
          report_and_stop;
        end
        @(posedge pclk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rchk(input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      repeat (2) @(posedge pclk);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
    end
  endtask
  // host never leaves a query pending, so no word-serial clear is due
  task cmd(input [3:0] c, input [1:0] inp);
    apb(1'b1, `OFS_CMD, {26'h0, inp, c});
  endtask
  task wrun(input [1:0] b, input v);
    begin
      n = 0;
      while (meas_run_r[b] !== v) begin
        n = n + 1;
        if (n > 300) begin
          err_count = err_count + 1;
          report_and_stop;
        end
        @(posedge pclk);
      end
    end
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, rear_trig} = 6'h00;
    {paddr, pwdata, front_cmp} = 47'h0;
    lat = 8'hC8;
    err_count = 0;
    cmp_count = 0;
    i = $urandom(58163);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // An ignored write to an unmapped word, then reset values
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    for (i = 1; i < 9; i = i + 1)
      rchk(12'(i * 4), 32'hFFFFFFFF, i < 3 ? 32'h22 : (i == 3 ? 32'h640 : 32'h0));
    // Level corners then random requests
    for (i = 0; i < 12; i = i + 1) begin
      mv = i == 0 ? -16'sh03E9 : i == 1 ? -16'sh03E8 : i == 2 ? 16'sh03E8 : i == 3 ? 16'sh03E9 :
           16'($urandom_range(10000)) - 16'h1388;
      apb(1'b1, `OFS_LEVEL_REQ, {16'h0000, mv});
      rchk(`OFS_CFG_START, 32'h30, {26'h0, qlvl(mv), 4'h0});
      chk({30'h0, front_lvl_r}, {30'h0, qlvl(mv)});
    end
    chk({29'h0, meas_run_r}, 32'h0);
    // Immediate arm with nothing initiated
    apb(1'b1, `OFS_IRQ_MASK, 32'h7);
    apb(1'b1, `OFS_CFG_START, {29'h0, `SRC_HOLD});
    apb(1'b1, `OFS_CFG_STOP, {29'h0, `SRC_HOLD});
    cmd(`CMD_IMM_START, 2'h1);
    rchk(`OFS_STATE, 32'hFF00, {16'h0, `ERR_ARM_IGN, 8'h0});
    chk({31'h0, irq}, 32'h1);
    rchk(`OFS_IRQ_STAT, 32'h1, 32'h1);
    rchk(`OFS_IRQ_STAT, 32'h1, 32'h0);
    // One-shot arms on hold sources
    cmd(`CMD_INIT, 2'h1);
    rchk(`OFS_STATE, 32'h3, 32'h1);
    cmd(`CMD_IMM_START, 2'h1);
    rchk(`OFS_STATE, 32'h3, 32'h1);
    lat <= 8'h02 + 8'($urandom_range(30));
    cmd(`CMD_IMM_STOP, 2'h1);
    wrun(2'h0, 1'b1);
    wrun(2'h0, 1'b0);
    rchk(`OFS_STATE, 32'h3, 32'h0);
    rchk(`OFS_IRQ_STAT, 32'h4, 32'h4);
    cmd(`CMD_INIT, 2'h1);
    repeat (20) @(posedge pclk);
    rchk(`OFS_STATE, 32'h3, 32'h1);
    rchk(`OFS_CFG_START, 32'h7, {29'h0, `SRC_HOLD});
    cmd(`CMD_ABORT, 2'h0);
    rchk(`OFS_STATE, 32'h3, 32'h0);
    // Front start with a different stop source
    apb(1'b1, `OFS_CFG_START, {29'h0, `SRC_FRONT});
    apb(1'b1, `OFS_CFG_STOP, {29'h0, `SRC_BUS});
    cmd(`CMD_INIT, 2'h1);
    rchk(`OFS_STATE, 32'hFF00, {16'h0, `ERR_CONFLICT, 8'h0});
    // Bus trigger on input two, then abort
    lat <= 8'hC8;
    apb(1'b1, `OFS_CFG_START, {29'h0, `SRC_BUS});
    cmd(`CMD_INIT, 2'h2);
    cmd(`CMD_TRIGGER, 2'h2);
    wrun(2'h1, 1'b1);
    cmd(`CMD_ABORT, 2'h2);
    rchk(`OFS_STATE, 32'hC, 32'h0);
    // Front arm at ground level: rising start, falling stop
    apb(1'b1, `OFS_LEVEL_REQ, 32'h0);
    apb(1'b1, `OFS_CFG_START, {29'h0, `SRC_FRONT});
    apb(1'b1, `OFS_CFG_STOP, {28'h0, 1'b1, `SRC_FRONT});
    cmd(`CMD_INIT, 2'h1);
    front_cmp <= 3'h4;
    repeat (4) @(posedge pclk);
    front_cmp <= 3'h2;
    repeat (4) @(posedge pclk);
    chk({29'h0, meas_run_r}, 32'h0);
    front_cmp <= 3'h0;
    wrun(2'h0, 1'b1);
    cmd(`CMD_FUNC, 2'h1);
    rchk(`OFS_STATE, 32'h3, 32'h0);
    // Rear trigger arms whatever the level
    apb(1'b1, `OFS_CFG_START, {29'h0, `SRC_REAR});
    apb(1'b1, `OFS_CFG_STOP, {29'h0, `SRC_REAR});
    cmd(`CMD_INIT, 2'h1);
    rear_trig <= 1'b1;
    wrun(2'h0, 1'b1);
    rear_trig <= 1'b0;
    cmd(`CMD_ABORT, 2'h1);
    // Continuous mode resumes after done and after abort
    apb(1'b1, `OFS_CFG_START, {29'h0, `SRC_IMM});
    apb(1'b1, `OFS_CFG_STOP, {29'h0, `SRC_IMM});
    apb(1'b1, `OFS_MODE, 32'h1);
    lat <= 8'h06;
    cmd(`CMD_INIT, 2'h1);
    wrun(2'h0, 1'b1);
    wrun(2'h0, 1'b0);
    wrun(2'h0, 1'b1);
    cmd(`CMD_ABORT, 2'h0);
    wrun(2'h0, 1'b1);
    apb(1'b1, `OFS_MODE, 32'h0);
    wrun(2'h0, 1'b0);
    rchk(`OFS_STATE, 32'h3, 32'h0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    report_and_stop;
  end
endmodule
